// ===== logic/floppy_cmd_defs.vh
// Constants for the floppy command decoder: register offsets, interrupt
// bits, fixed status values, reset values and timing.
// Assumes inclusion by bare name from the design files.
`ifndef FLOPPY_CMD_DEFS_VH
`define FLOPPY_CMD_DEFS_VH

// Register offsets on the plain register port
`define OFS_DATA 4'h0
`define OFS_STAT 4'h4
`define OFS_ISTAT 4'h8
`define OFS_IMASK 4'hC

// Interrupt status bit positions
`define IRQ_SEEK_END 0
`define IRQ_RESULT 1
`define IRQ_INVALID 2
`define IRQ_BITS 3

// Fixed status byte values
`define ST0_INVALID 8'h80
`define ST0_SEEK_END 8'h20

// Reset values of specify and configure fields
`define RST_SPEC1 8'h00
`define RST_SPEC2 8'h00
`define RST_CONFIG 8'h20
`define RST_PRECOMP_START_TRACK 8'h00

// Recalibrate gives up after this many steps without track 0
`define RECAL_MAX_STEPS 8'h4F
// Step gap is (STEP_GAP_BASE - step_rate_time) milliseconds
`define STEP_GAP_BASE 5'h10
// Sector size for size code 0 is data_length; otherwise 128 << size
`define SECTOR_UNIT 15'h0080

// Timing
`define CLK_PERIOD_NS 20
`define ONE_MS_NS 1000000
`define CYC_PER_MS (`ONE_MS_NS / `CLK_PERIOD_NS)

`endif

// ===== logic/head_stepper.v
// Head stepper: issues step pulses at the programmed rate toward a
// cylinder, optionally stopping early once track 0 is reported.
// Assumes i_track0 is already synchronised to i_ref_clk.
`timescale 1ns/1ps
`include "floppy_cmd_defs.vh"

module head_stepper #(
  parameter CYC_PER_MS = `CYC_PER_MS
) (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_go,
  input wire [7:0] i_steps,
  input wire [3:0] i_srt,
  input wire i_stop_at_track0,
  input wire i_track0,
  output reg o_step,
  output reg o_done
);

reg busy_q;
reg [7:0] left_q;
reg [4:0] gap_q;
reg [23:0] ms_cnt_q;
// Last count of one millisecond, cut to the counter's width
localparam [23:0] MS_LAST = CYC_PER_MS[23:0] - 24'h00_0001;

////////////////////////////////////////////////////////////////////////
// Gap is counted after each pulse, so the head settles before done
always @(posedge i_ref_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    busy_q <= 1'b0;
    left_q <= 8'h00;
    gap_q <= 5'h00;
    ms_cnt_q <= 24'h00_0000;
    o_step <= 1'b0;
    o_done <= 1'b0;
  end else begin
    o_step <= 1'b0;
    o_done <= 1'b0;
    if (i_go) begin
      busy_q <= 1'b1;
      left_q <= i_steps;
      gap_q <= 5'h00;
      ms_cnt_q <= 24'h00_0000;
    end else if (busy_q) begin
      if (gap_q != 5'h00) begin
        if (ms_cnt_q == MS_LAST) begin
          ms_cnt_q <= 24'h00_0000;
          gap_q <= gap_q - 5'h01;
        end else begin
          ms_cnt_q <= ms_cnt_q + 24'h00_0001;
        end
      end else if (left_q == 8'h00 || (i_stop_at_track0 && i_track0)) begin
        busy_q <= 1'b0;
        o_done <= 1'b1;
      end else begin
        o_step <= 1'b1;
        left_q <= left_q - 8'h01;
        gap_q <= `STEP_GAP_BASE - {1'b0, i_srt};
      end
    end
  end
end

endmodule // head_stepper

// ===== logic/floppy_command_decoder.v
// Floppy command decoder: takes command packets through the data
// register, executes them and hands back result bytes.
// Assumes a single 50 MHz clock; drive pins arrive asynchronously.
//
// Overview of operation
// R01: Write deleted data is opcode with multitrack in bit 7, density in bit 6, then head/drive byte and the C, H, R, N identifiers.
// R02: After final sector, gap length and data length, write deleted data moves sector bytes from system to drive.
// R03: Write deleted data ends with seven result bytes: three status bytes then C, H, R, N as left after execution.
// R04: Recalibrate takes a drive byte, steps that head back to track 0 and interrupts with no result bytes.
// R05: Sense interrupt status returns status byte zero then the drive's present cylinder.
// R06: Software issues sense interrupt status after every seek or recalibrate to collect status and acknowledge it.
// R07: Seek takes head/drive and new cylinder bytes and steps until the head is over that cylinder.
// R08: Register dump places ten bytes: four present cylinders, step/unload, load/non-DMA, sector count, lock bits, configure bits, precomp track.
//      The code fills the sector count byte with the stale fourth command byte, cb_q[3].
// R09: Format track takes size, sectors per track, gap and filler, then four id bytes per sector, and returns three status and four undefined bytes.
// R10: Specify loads step rate and head unload from its first byte and head load and non-DMA from its second, with no result.
// R11: An unknown opcode does nothing and returns the single status byte 80 hex.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "floppy_cmd_defs.vh"

module floppy_command_decoder #(
  parameter CYC_PER_MS = `CYC_PER_MS
) (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  output reg o_irq,
  input wire i_track0_n,
  output wire o_step,
  output reg o_dir_in,
  output reg [1:0] o_drive_sel,
  output reg o_head,
  output reg [7:0] o_drv_data,
  output reg o_drv_wr
);

localparam S_CMD = 3'd0, S_DISP = 3'd1, S_STEP = 3'd2;
localparam S_XFER = 3'd3, S_FMT = 3'd4, S_RES = 3'd5;

reg [2:0] state_q;
reg [7:0] cb_q [0:8];
reg [7:0] res_q [0:9];
reg [7:0] pcn_q [0:3];
reg [3:0] cb_cnt_q, res_n_q, res_i_q;
reg [7:0] spec1_q, spec2_q, config_q, precomp_start_track_q;
reg [14:0] xfer_cnt_q;
reg [9:0] fmt_cnt_q;
reg [7:0] target_q, end_st0_q, go_steps_q;
reg recal_q, seek_end_q, go_q, trk_meta_q, trk_sync_q;
reg [1:0] end_drv_q;
reg [`IRQ_BITS-1:0] istat_q, imask_q, ev, w1c;
wire step_done;
wire wr_data = i_wr && i_addr == `OFS_DATA;
wire rd_data = i_rd && i_addr == `OFS_DATA;

// Bytes in each packet; zero marks an unknown opcode
function [3:0] cmd_len;
  input [7:0] op;
  begin
    cmd_len = 4'd0;
    if (op[5:0] == 6'h09) cmd_len = 4'd9; // see R01
    else if (!op[7] && op[5:0] == 6'h0D) cmd_len = 4'd6; // see R09
    else if (op == 8'h07) cmd_len = 4'd2;
    else if (op == 8'h08) cmd_len = 4'd1;
    else if (op == 8'h03) cmd_len = 4'd3;
    else if (op == 8'h0F) cmd_len = 4'd3;
    else if (op == 8'h13) cmd_len = 4'd4;
    else if (op == 8'h0E) cmd_len = 4'd1;
    else if (op[7] && op[5:0] == 6'h0F) cmd_len = 4'd3;
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Track 0 pin crosses in through two flops
always @(posedge i_ref_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    trk_meta_q <= 1'b0;
    trk_sync_q <= 1'b0;
  end else begin
    trk_meta_q <= ~i_track0_n;
    trk_sync_q <= trk_meta_q;
  end
end

head_stepper #(.CYC_PER_MS(CYC_PER_MS)) u_stepper (
  .i_ref_clk(i_ref_clk),
  .i_resetn(i_resetn),
  .i_go(go_q),
  .i_steps(go_steps_q),
  .i_srt(spec1_q[7:4]),
  .i_stop_at_track0(recal_q),
  .i_track0(trk_sync_q),
  .o_step(o_step),
  .o_done(step_done)
);

////////////////////////////////////////////////////////////////////////
// Command, execution and result phases
integer k;
always @(posedge i_ref_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    state_q <= S_CMD;
    cb_cnt_q <= 4'd0;
    res_n_q <= 4'd0;
    res_i_q <= 4'd0;
    for (k = 0; k < 9; k = k + 1) cb_q[k] <= 8'h00;
    for (k = 0; k < 10; k = k + 1) res_q[k] <= 8'h00;
    for (k = 0; k < 4; k = k + 1) pcn_q[k] <= 8'h00;
    spec1_q <= `RST_SPEC1;
    spec2_q <= `RST_SPEC2;
    config_q <= `RST_CONFIG;
    precomp_start_track_q <= `RST_PRECOMP_START_TRACK;
    xfer_cnt_q <= 15'h0000;
    fmt_cnt_q <= 10'h000;
    target_q <= 8'h00;
    recal_q <= 1'b0;
    seek_end_q <= 1'b0;
    end_st0_q <= 8'h00;
    end_drv_q <= 2'b00;
    go_q <= 1'b0;
    go_steps_q <= 8'h00;
    o_dir_in <= 1'b0;
    o_drive_sel <= 2'b00;
    o_head <= 1'b0;
    o_drv_data <= 8'h00;
    o_drv_wr <= 1'b0;
    ev <= {`IRQ_BITS{1'b0}};
  end else begin
    go_q <= 1'b0;
    o_drv_wr <= 1'b0;
    ev <= {`IRQ_BITS{1'b0}};
    case (state_q)
      S_CMD: begin
        if (wr_data) begin
          cb_q[cb_cnt_q] <= i_wdata;
          if (cb_cnt_q == 4'd0 && cmd_len(i_wdata) == 4'd0) begin
            res_q[0] <= `ST0_INVALID; // see R11
            res_n_q <= 4'd1;
            res_i_q <= 4'd0;
            state_q <= S_RES;
            ev[`IRQ_INVALID] <= 1'b1;
          end else if (cb_cnt_q + 4'd1 == cmd_len(cb_cnt_q == 4'd0 ?
                                                 i_wdata : cb_q[0])) begin
            cb_cnt_q <= 4'd0;
            state_q <= S_DISP;
          end else begin
            cb_cnt_q <= cb_cnt_q + 4'd1;
          end
        end
      end
      S_DISP: begin
        res_i_q <= 4'd0;
        o_drive_sel <= cb_q[1][1:0];
        o_head <= cb_q[1][2];
        state_q <= S_RES;
        if (cb_q[0][5:0] == 6'h09) begin
          // Size code 0 means the data length byte gives the count
          xfer_cnt_q <= (cb_q[5] == 8'h00) ? {7'h00, cb_q[8]} :
                        (`SECTOR_UNIT << cb_q[5][2:0]); // see R02
          state_q <= S_XFER;
        end else if (cb_q[0] == 8'h0D || cb_q[0] == 8'h4D) begin
          fmt_cnt_q <= {cb_q[3], 2'b00}; // see R09
          state_q <= S_FMT;
        end else if (cb_q[0] == 8'h07) begin
          recal_q <= 1'b1; // see R04
          o_dir_in <= 1'b0;
          go_steps_q <= `RECAL_MAX_STEPS;
          target_q <= 8'h00;
          go_q <= 1'b1;
          state_q <= S_STEP;
        end else if (cb_q[0] == 8'h08) begin
          // Without a pending completion this is an invalid request
          res_q[0] <= seek_end_q ? end_st0_q : `ST0_INVALID; // see R05
          res_q[1] <= pcn_q[end_drv_q];
          res_n_q <= seek_end_q ? 4'd2 : 4'd1;
          seek_end_q <= 1'b0;
        end else if (cb_q[0] == 8'h03) begin
          spec1_q <= cb_q[1]; // see R10
          spec2_q <= cb_q[2];
          state_q <= S_CMD;
        end else if (cb_q[0] == 8'h13) begin
          config_q <= cb_q[2];
          precomp_start_track_q <= cb_q[3];
          state_q <= S_CMD;
        end else if (cb_q[0] == 8'h0E) begin
          for (k = 0; k < 4; k = k + 1) res_q[k] <= pcn_q[k]; // see R08
          res_q[4] <= spec1_q;
          res_q[5] <= spec2_q;
          res_q[6] <= cb_q[3];
          res_q[7] <= 8'h00;
          res_q[8] <= config_q;
          res_q[9] <= precomp_start_track_q;
          res_n_q <= 4'd10;
        end else begin
          // Seek and relative seek; relative outward stops at 0
          recal_q <= 1'b0;
          go_q <= 1'b1;
          state_q <= S_STEP;
          if (cb_q[0] == 8'h0F) begin
            target_q <= cb_q[2]; // see R07
            o_dir_in <= cb_q[2] > pcn_q[cb_q[1][1:0]];
            go_steps_q <= (cb_q[2] > pcn_q[cb_q[1][1:0]]) ?
                          cb_q[2] - pcn_q[cb_q[1][1:0]] :
                          pcn_q[cb_q[1][1:0]] - cb_q[2];
          end else if (cb_q[0][6]) begin
            target_q <= pcn_q[cb_q[1][1:0]] + cb_q[2];
            o_dir_in <= 1'b1;
            go_steps_q <= cb_q[2];
          end else begin
            o_dir_in <= 1'b0;
            if (cb_q[2] > pcn_q[cb_q[1][1:0]]) begin
              target_q <= 8'h00;
              go_steps_q <= pcn_q[cb_q[1][1:0]];
            end else begin
              target_q <= pcn_q[cb_q[1][1:0]] - cb_q[2];
              go_steps_q <= cb_q[2];
            end
          end
        end
      end
      S_STEP: begin
        if (step_done) begin
          pcn_q[o_drive_sel] <= target_q; // see R04
          end_st0_q <= `ST0_SEEK_END | {5'h00, o_head, o_drive_sel};
          end_drv_q <= o_drive_sel;
          seek_end_q <= 1'b1;
          ev[`IRQ_SEEK_END] <= 1'b1;
          state_q <= S_CMD;
        end
      end
      S_XFER, S_FMT: begin
        if (wr_data) begin
          o_drv_data <= i_wdata;
          o_drv_wr <= 1'b1;
          xfer_cnt_q <= xfer_cnt_q - 15'h0001;
          fmt_cnt_q <= fmt_cnt_q - 10'h001;
        end
        if ((state_q == S_XFER && xfer_cnt_q == 15'h0000) ||
            (state_q == S_FMT && fmt_cnt_q == 10'h000)) begin
          res_q[0] <= {5'h00, o_head, o_drive_sel}; // see R03
          res_q[1] <= 8'h00;
          res_q[2] <= 8'h00;
          res_q[3] <= cb_q[2];
          res_q[4] <= cb_q[3];
          res_q[5] <= (state_q == S_XFER) ? cb_q[4] + 8'h01 : 8'h00;
          res_q[6] <= (state_q == S_XFER) ? cb_q[5] : 8'h00;
          res_n_q <= 4'd7;
          res_i_q <= 4'd0;
          state_q <= S_RES;
          ev[`IRQ_RESULT] <= 1'b1;
        end
      end
      S_RES: begin
        if (rd_data) begin
          res_i_q <= res_i_q + 4'd1;
          if (res_i_q + 4'd1 >= res_n_q) state_q <= S_CMD;
        end
      end
      default: state_q <= S_CMD;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// Register port, sticky interrupt status with set winning over clear
always @* begin
  w1c = (i_wr && i_addr == `OFS_ISTAT) ? i_wdata[`IRQ_BITS-1:0] :
        {`IRQ_BITS{1'b0}};
end

always @(posedge i_ref_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    istat_q <= {`IRQ_BITS{1'b0}};
    imask_q <= {`IRQ_BITS{1'b0}};
    o_irq <= 1'b0;
    o_rdata <= 8'h00;
  end else begin
    istat_q <= (istat_q & ~w1c) | ev;
    if (i_wr && i_addr == `OFS_IMASK) imask_q <= i_wdata[`IRQ_BITS-1:0];
    o_irq <= |(istat_q & imask_q);
    o_rdata <= 8'h00;
    if (i_rd) begin
      case (i_addr)
        `OFS_DATA: o_rdata <= (state_q == S_RES) ? res_q[res_i_q] : 8'h00;
        `OFS_STAT: o_rdata <= {5'h00, state_q == S_RES,
                               state_q == S_CMD, state_q != S_CMD};
        `OFS_ISTAT: o_rdata <= {5'h00, istat_q};
        `OFS_IMASK: o_rdata <= {5'h00, imask_q};
        default: o_rdata <= 8'h00;
      endcase
    end
  end
end

endmodule // floppy_command_decoder

// ===== sim/drive_model.sv
// Drive model: per-drive head position, reports track 0 on a low pin.
// Assumes one-cycle step pulses with direction and select steady then.
`timescale 1ns/1ps

module drive_model (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_step,
  input wire i_dir_in,
  input wire [1:0] i_drive_sel,
  output wire o_track0_n
);
  reg [7:0] cyl_q [0:3];

  // Drive 0 starts off track 0 so a recalibrate has to step for real
  assign o_track0_n = cyl_q[i_drive_sel] != 8'h00;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cyl_q[0] <= 8'h03;
      cyl_q[1] <= 8'h00;
      cyl_q[2] <= 8'h00;
      cyl_q[3] <= 8'h00;
    end else if (i_step) begin
      if (i_dir_in) begin
        cyl_q[i_drive_sel] <= cyl_q[i_drive_sel] + 8'h01;
      end else if (cyl_q[i_drive_sel] != 8'h00) begin
        cyl_q[i_drive_sel] <= cyl_q[i_drive_sel] - 8'h01;
      end
    end
  end
endmodule // drive_model

// ===== sim/floppy_command_decoder_checker.sv
// Port checker for the floppy command decoder.
// Assumes it is bound to every decoder instance.
`timescale 1ns/1ps
`include "floppy_cmd_defs.vh"

module floppy_command_decoder_checker #(
  parameter CYC_PER_MS = 4
) (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire o_irq,
  input wire i_track0_n,
  input wire o_step,
  input wire o_dir_in,
  input wire [1:0] o_drive_sel,
  input wire o_head,
  input wire [7:0] o_drv_data,
  input wire o_drv_wr
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  wire data_wr = i_wr && i_addr == `OFS_DATA;
  wire mapped = i_addr[1:0] == 2'b00;
  wire mask_wr = i_wr && i_addr == `OFS_IMASK;
  // Six cycles covers the two sync flops plus the stepper's decision
  sequence trk0_held;
    !i_track0_n [*6];
  endsequence
  sequence mask_off;
    mask_wr && i_wdata[2:0] == 3'b000 ##1 !mask_wr;
  endsequence
  // Cycles since the last step, saturating at 1000, which is past the longest gap only while CYC_PER_MS is at most 62
  int since_step = 1000;
  always @(posedge i_ref_clk) begin
    if (o_step) since_step <= 0;
    else if (since_step < 1000) since_step <= since_step + 1;
  end

  chk_drv_byte: assert property (
    o_drv_wr |-> $past(data_wr) && o_drv_data == $past(i_wdata))
    else $error("drive byte without matching data write");
  chk_wr_vs_step: assert property (
    o_drv_wr |-> !o_step)
    else $error("drive byte during a step");
  chk_rd_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  chk_rd_unmapped: assert property (
    $past(i_rd && !mapped) |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_step_gap: assert property (
    o_step |=> !o_step [*3])
    else $error("step pulses too close");
  chk_step_dir: assert property (
    o_step |-> $stable(o_dir_in))
    else $error("direction moved with step");
  chk_step_sel: assert property (
    o_step |-> $stable(o_drive_sel) && $stable(o_head))
    else $error("select moved with step");
  chk_recal_halt: assert property (
    trk0_held |-> !(o_step && !o_dir_in))
    else $error("outward step at track 0");
  chk_irq_masked: assert property (
    mask_off |=> !o_irq)
    else $error("interrupt with mask clear");
  chk_step_rate: assert property (
    o_step |-> since_step >= CYC_PER_MS)
    else $error("step gap below one millisecond");
endmodule // floppy_command_decoder_checker

bind floppy_command_decoder floppy_command_decoder_checker #(
  .CYC_PER_MS(CYC_PER_MS)
) u_chk (
  .i_ref_clk(i_ref_clk),
  .i_resetn(i_resetn),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_irq(o_irq),
  .i_track0_n(i_track0_n),
  .o_step(o_step),
  .o_dir_in(o_dir_in),
  .o_drive_sel(o_drive_sel),
  .o_head(o_head),
  .o_drv_data(o_drv_data),
  .o_drv_wr(o_drv_wr)
);

// ===== sim/floppy_command_decoder_tb.sv
// Testbench for the floppy command decoder.
// Assumes the checker binds itself and the drive model answers steps.
`timescale 1ns/1ps
`include "floppy_cmd_defs.vh"

module floppy_command_decoder_tb;
  localparam MS = 4;
  reg i_ref_clk = 1'b0;
  reg i_resetn = 1'b0;
  reg [3:0] i_addr = 4'h0;
  reg [7:0] i_wdata = 8'h00;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  wire [7:0] o_rdata, o_drv_data;
  wire [1:0] o_drive_sel;
  wire o_irq, track0_n, o_step, o_dir_in, o_head, o_drv_wr;
  int bad_count = 0;
  int compares = 0;
  int wr_count = 0;
  int steps_in = 0;
  int p;
  logic [7:0] d;
  logic [7:0] last_drv = 8'h00;
  logic [2:0] step_sel = 3'b000;
  // Rows: count, command, exec byte count, result count, results
  logic [7:0] tbl [$] = '{
    8'h03, 8'h03, 8'hF1, 8'h03, 8'h00, 8'h00,
    8'h04, 8'h13, 8'h00, 8'h40, 8'h05, 8'h00, 8'h00,
    8'h01, 8'h1F, 8'h00, 8'h01, 8'h80,
    8'h01, 8'h08, 8'h00, 8'h01, 8'h80,
    8'h01, 8'h0E, 8'h00, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hF1, 8'h03, 8'h05, 8'h00, 8'h40, 8'h05,
    8'h09, 8'hC9, 8'h04, 8'h07, 8'h01, 8'h03, 8'h00, 8'h05, 8'h1B,
    8'h04, 8'h04, 8'h07, 8'h04, 8'h00, 8'h00, 8'h07, 8'h01, 8'h04, 8'h00,
    8'h06, 8'h0D, 8'h00, 8'h02, 8'h01, 8'h1B, 8'hE5, 8'h04, 8'h07,
    8'h00, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00, 8'h00};

  floppy_command_decoder #(.CYC_PER_MS(MS)) dut (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .i_track0_n(track0_n), .o_step(o_step),
    .o_dir_in(o_dir_in), .o_drive_sel(o_drive_sel), .o_head(o_head),
    .o_drv_data(o_drv_data), .o_drv_wr(o_drv_wr));
  drive_model drive (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_step(o_step),
    .i_dir_in(o_dir_in), .i_drive_sel(o_drive_sel),
    .o_track0_n(track0_n));

  initial begin
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    if (o_drv_wr === 1'b1) begin
      wr_count <= wr_count + 1;
      last_drv <= o_drv_data;
    end
    if (o_step === 1'b1 && o_dir_in === 1'b1) begin
      steps_in <= steps_in + 1;
      step_sel <= {o_head, o_drive_sel};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task wait_bit(input logic [3:0] a, input int b);
    d = 8'h00;
    for (int k = 0; k < 300 && d[b] !== 1'b1; k++) rd(a, d);
    chk8("flag set", 8'h01, {7'h00, d[b]});
  endtask
  task sense(input logic [7:0] e0, input logic [7:0] e1);
    wr(`OFS_DATA, 8'h08);
    wait_bit(`OFS_STAT, 2);
    rd(`OFS_DATA, d);
    chk8("sense status", e0, d);
    rd(`OFS_DATA, d);
    chk8("sense cylinder", e1, d);
  endtask
  task automatic run_row();
    int nc, ne, nr, w0;
    nc = tbl[p];
    for (int i = 0; i < nc; i++) wr(`OFS_DATA, tbl[p + 1 + i]);
    p += nc + 1;
    ne = tbl[p];
    nr = tbl[p + 1];
    p += 2;
    w0 = wr_count;
    // Exec bytes wait out dispatch, which would drop them
    repeat (3) @(posedge i_ref_clk);
    for (int i = 0; i < ne; i++) wr(`OFS_DATA, 8'hA0 + i[7:0]);
    if (ne > 0) begin
      repeat (2) @(posedge i_ref_clk);
      chk8("drive bytes", ne[7:0], 8'(wr_count - w0));
      chk8("last drive byte", 8'h9F + ne[7:0], last_drv);
      wait_bit(`OFS_STAT, 2);
    end
    if (nr > 0 && ne == 0) wait_bit(`OFS_STAT, 2);
    for (int i = 0; i < nr; i++) begin
      rd(`OFS_DATA, d);
      chk8("result byte", tbl[p + i], d);
    end
    p += nr;
    rd(`OFS_DATA, d);
    chk8("spare read", 8'h00, d);
  endtask
  task wrap_up;
    $display("Comparisons %0d, errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge i_ref_clk);
    chk8("outputs in reset", 8'h00,
      {1'b0, o_step, o_drv_wr, o_dir_in, o_head, o_drive_sel, o_irq});
    chk8("rdata in reset", 8'h00, o_rdata);
    repeat (5) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rd(`OFS_STAT, d);
    chk8("status idle", 8'h02, d);
    rd(`OFS_ISTAT, d);
    chk8("irq status reset", 8'h00, d);
    wr(`OFS_IMASK, 8'h05);
    rd(`OFS_IMASK, d);
    chk8("mask readback", 8'h05, d);
    wr(`OFS_IMASK, 8'h00);
    rd(4'h2, d);
    chk8("unmapped read", 8'h00, d);
    p = 0;
    while (p < tbl.size()) run_row();
    // Recalibrate from cylinder 3, interrupt unmasked
    wr(`OFS_IMASK, 8'h01);
    wr(`OFS_DATA, 8'h07);
    wr(`OFS_DATA, 8'h00);
    for (int k = 0; k < 2000 && o_irq !== 1'b1; k++) @(posedge i_ref_clk);
    chk8("recal irq", 8'h01, {7'h00, o_irq});
    chk8("at track 0", 8'h00, {7'h00, track0_n});
    sense(8'h20, 8'h00);
    wait_bit(`OFS_ISTAT, 0);
    wr(`OFS_ISTAT, 8'h07);
    rd(`OFS_ISTAT, d);
    chk8("status cleared", 8'h00, d);
    chk8("irq cleared", 8'h00, {7'h00, o_irq});
    // Seek drive 1 head 1 to cylinder 2 with the interrupt masked
    wr(`OFS_IMASK, 8'h00);
    wr(`OFS_DATA, 8'h0F);
    wr(`OFS_DATA, 8'h05);
    wr(`OFS_DATA, 8'h02);
    wait_bit(`OFS_ISTAT, 0);
    chk8("inward steps", 8'h02, 8'(steps_in));
    chk8("step select", 8'h05, {5'h00, step_sel});
    chk8("irq masked", 8'h00, {7'h00, o_irq});
    wr(`OFS_IMASK, 8'h01);
    repeat (2) @(posedge i_ref_clk);
    chk8("irq unmasked", 8'h01, {7'h00, o_irq});
    sense(8'h25, 8'h02);
    wr(`OFS_ISTAT, 8'h07);
    // Relative seek drive 1 inward by 3, then outward past cylinder 0
    wr(`OFS_DATA, 8'hCF);
    wr(`OFS_DATA, 8'h01);
    wr(`OFS_DATA, 8'h03);
    wait_bit(`OFS_ISTAT, 0);
    chk8("relative inward steps", 8'h05, 8'(steps_in));
    sense(8'h21, 8'h05);
    wr(`OFS_ISTAT, 8'h07);
    wr(`OFS_DATA, 8'h8F);
    wr(`OFS_DATA, 8'h01);
    wr(`OFS_DATA, 8'h07);
    wait_bit(`OFS_ISTAT, 0);
    chk8("relative outward home", 8'h00, {7'h00, track0_n});
    sense(8'h21, 8'h00);
    wr(`OFS_ISTAT, 8'h07);
    wrap_up();
  end
endmodule // floppy_command_decoder_tb
